// >>> src/pin_routing_pkg.sv
// Package for the peripheral pin routing block: register map, field positions,
// reset values, routed-signal indices and bus response codes.
// Assumes a single system clock domain and an AXI4-Lite register master.
package pin_routing_pkg;

    // ----------------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------------
    localparam logic [7:0] ROUTE_SELECT_0_OFFSET = 8'h00;
    localparam logic [7:0] ROUTE_SELECT_1_OFFSET = 8'h04;
    localparam logic [7:0] ROUTE_STATUS_OFFSET = 8'h08;

    localparam logic [7:0] ROUTE_SELECT_0_RESET = 8'h00;
    localparam logic [7:0] ROUTE_SELECT_1_RESET = 8'h00;
    // Bits 5, 1 and 0 of select 1 are unused or reserved and read as zero
    localparam logic [7:0] ROUTE_SELECT_1_WRITE_MASK = 8'hDC;

    // ----------------------------------------------------------------------
    // Field positions, select 0
    // ----------------------------------------------------------------------
    localparam int SYSCLK_OUT_ROUTE_BIT = 7;
    localparam int TIMER2_AUX_ROUTE_BIT = 6;
    localparam int TIMER2_INPUT_ROUTE_BIT = 5;
    localparam int IRQ_ONE_ROUTE_BIT = 4;
    localparam int TIMER_ONE_INPUT_ROUTE_BIT = 3;
    localparam int IRQ_ZERO_ROUTE_BIT = 2;
    localparam int TIMER_ZERO_INPUT_ROUTE_BIT = 1;
    localparam int COMPARATOR_ONE_ROUTE_BIT = 0;

    // ----------------------------------------------------------------------
    // Field positions, select 1
    // ----------------------------------------------------------------------
    localparam int WEAK_PULLUP_DISABLE_BIT = 7;
    localparam int ROUTE_MATRIX_ENABLE_BIT = 6;
    localparam int TIMER4_AUX_ROUTE_BIT = 4;
    localparam int TIMER4_INPUT_ROUTE_BIT = 3;
    localparam int SECOND_SERIAL_ROUTE_BIT = 2;

    // ----------------------------------------------------------------------
    // Routed signals, listed in assignment priority (index 0 first)
    // ----------------------------------------------------------------------
    localparam int SIG_COUNT = 10;
    localparam int SIG_W = 4;
    localparam logic [3:0] SIG_SERIAL_TX = 4'h0;
    localparam logic [3:0] SIG_SERIAL_RX = 4'h1;
    localparam logic [3:0] SIG_COMPARATOR = 4'h2;
    localparam logic [3:0] SIG_TIMER_ZERO = 4'h3;
    localparam logic [3:0] SIG_IRQ_ZERO = 4'h4;
    localparam logic [3:0] SIG_TIMER_ONE = 4'h5;
    localparam logic [3:0] SIG_IRQ_ONE = 4'h6;
    localparam logic [3:0] SIG_TIMER_TWO = 4'h7;
    localparam logic [3:0] SIG_TIMER_TWO_AUX = 4'h8;
    localparam logic [3:0] SIG_SYSCLK_OUT = 4'h9;

    // Level seen by a peripheral input that has no pin
    localparam logic INPUT_IDLE_LEVEL = 1'b1;

    // ----------------------------------------------------------------------
    // Bus
    // ----------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        REG_SELECT_0,
        REG_SELECT_1,
        REG_STATUS,
        REG_NONE
    } reg_sel_e;

endpackage : pin_routing_pkg

// >>> src/route_slot_assigner.sv
// Priority assigner: hands enabled signals to port pins in index order,
// one signal per pin, skipping pins that are marked for skipping.
// Purely combinational; the caller registers whatever it drives out.
module route_slot_assigner #(
    parameter int NUM_PINS = 8
) (
    input wire logic [pin_routing_pkg::SIG_COUNT-1:0] sig_enable,
    input wire logic [NUM_PINS-1:0] pin_skip,
    output logic [NUM_PINS-1:0] pin_valid,
    output logic [NUM_PINS-1:0][pin_routing_pkg::SIG_W-1:0] pin_sig,
    output logic overflow
);

    // ----------------------------------------------------------------------
    // Assignment walk
    // ----------------------------------------------------------------------
    always_comb
    begin
        int next_sig;
        logic found;
        next_sig = 0;
        found = 1'b0;
        overflow = 1'b0;
        for (int p = 0; p < NUM_PINS; p++)
        begin
            pin_valid[p] = 1'b0;
            pin_sig[p] = '0;
            found = 1'b0;
            if (!pin_skip[p]) // RULE9
            begin
                for (int s = 0; s < pin_routing_pkg::SIG_COUNT; s++)
                begin
                    if (!found && s >= next_sig && sig_enable[s]) // RULE8
                    begin
                        found = 1'b1;
                        pin_sig[p] = pin_routing_pkg::SIG_W'(s);
                    end
                end
                if (found)
                begin
                    pin_valid[p] = 1'b1;
                    next_sig = int'(pin_sig[p]) + 1;
                end
            end
        end
        // Enabled signals left over when the pins ran out
        for (int s = 0; s < pin_routing_pkg::SIG_COUNT; s++)
        begin
            if (s >= next_sig && sig_enable[s])
            begin
                overflow = 1'b1;
            end
        end
    end

endmodule : route_slot_assigner

// >>> src/peripheral_pin_routing.sv
// Peripheral pin routing: two route select registers behind an AXI4-Lite
// slave, and the crossbar that places enabled peripheral signals on port pins.
// Assumes pins are asynchronous to aclk and that analog-mode and port-latch
// controls come from logic on aclk.
//
// Behaviour
// [RULE1] Timer-two count input takes a pin only while its route bit is set, else it sees idle.
// [RULE2] Interrupt-one input (active low) takes a pin only while its route bit is set.
// [RULE3] Timer-one count input takes a pin only while its route bit is set.
// [RULE4] Interrupt-zero input (active low) takes a pin only while its route bit is set.
// [RULE5] Timer-zero count input takes a pin only while its route bit is set.
// [RULE6] Comparator-one output is driven onto a pin only while its route bit is set.
// [RULE7] Second serial port transmit and receive take two pins only while its route bit is set.
// [RULE8] Enabled signals go to pins in fixed priority order, each to the next unskipped pin.
// [RULE9] A pin in analog input mode is skipped and never receives a signal.
// [RULE10] With the matrix enable clear, every pin is in input mode and nothing is routed.
module peripheral_pin_routing #(
    parameter int NUM_PINS = 8,
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe_n,
    input wire logic [NUM_PINS-1:0] pin_analog_mode,
    input wire logic [NUM_PINS-1:0] gpio_out,
    input wire logic [NUM_PINS-1:0] gpio_drive,
    input wire logic second_serial_port_tx,
    output logic second_serial_port_rx,
    input wire logic comparator_one_output,
    input wire logic sysclk_level,
    output logic timer_zero_count_input,
    output logic timer_one_count_input,
    output logic timer_two_count_input,
    output logic timer_two_aux_input,
    output logic external_irq_zero_input_n,
    output logic external_irq_one_input_n,
    output logic weak_pullup_enable,
    output logic route_matrix_enable,
    output logic [NUM_PINS-1:0] pin_assigned
);

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    function automatic pin_routing_pkg::reg_sel_e decode_addr(input logic [ADDR_W-1:0] addr);
        logic [7:0] word;
        word = {addr[7:2], 2'b00};
        case (word)
            pin_routing_pkg::ROUTE_SELECT_0_OFFSET: return pin_routing_pkg::REG_SELECT_0;
            pin_routing_pkg::ROUTE_SELECT_1_OFFSET: return pin_routing_pkg::REG_SELECT_1;
            pin_routing_pkg::ROUTE_STATUS_OFFSET: return pin_routing_pkg::REG_STATUS;
            default: return pin_routing_pkg::REG_NONE;
        endcase
    endfunction : decode_addr

    function automatic logic is_output_signal(input logic [3:0] idx);
        return idx == pin_routing_pkg::SIG_SERIAL_TX || idx == pin_routing_pkg::SIG_COMPARATOR
            || idx == pin_routing_pkg::SIG_SYSCLK_OUT;
    endfunction : is_output_signal

    // ----------------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------------
    logic [7:0] peripheral_route_select_0_r;
    logic [7:0] peripheral_route_select_1_r;
    logic aw_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic w_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [NUM_PINS-1:0] sync1_r;
    logic [NUM_PINS-1:0] sync2_r;
    logic [NUM_PINS-1:0] sync3_r;
    logic [NUM_PINS-1:0] pin_level_r;
    logic [NUM_PINS-1:0] pin_out_r;
    logic [NUM_PINS-1:0] pin_oe_n_r;
    logic [NUM_PINS-1:0] pin_assigned_r;
    logic overflow_r;
    logic [pin_routing_pkg::SIG_COUNT-1:0] sig_in_r;

    logic write_go;
    logic read_go;
    pin_routing_pkg::reg_sel_e wr_sel;
    pin_routing_pkg::reg_sel_e rd_sel;
    logic matrix_en;
    logic [pin_routing_pkg::SIG_COUNT-1:0] sig_enable;
    logic [NUM_PINS-1:0] slot_valid;
    logic [NUM_PINS-1:0][pin_routing_pkg::SIG_W-1:0] slot_sig;
    logic slot_overflow;
    logic [NUM_PINS-1:0] pin_out_nxt;
    logic [NUM_PINS-1:0] pin_oe_n_nxt;
    logic [pin_routing_pkg::SIG_COUNT-1:0] sig_in_nxt;
    logic [pin_routing_pkg::SIG_COUNT-1:0] sig_drive;
    logic [31:0] read_value;

    // ----------------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------------
    // Address and data are caught independently; the write fires once both are held.
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign write_go = aw_held_r && w_held_r && !bvalid_r;
    assign wr_sel = decode_addr(aw_addr_r);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            else if (write_go)
            begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            else if (write_go)
            begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= pin_routing_pkg::RESP_OKAY;
        end
        else if (write_go)
        begin
            bvalid_r <= 1'b1;
            // Status is read-only, so a write to it is refused like a hole
            bresp_r <= (wr_sel == pin_routing_pkg::REG_SELECT_0
                || wr_sel == pin_routing_pkg::REG_SELECT_1)
                ? pin_routing_pkg::RESP_OKAY : pin_routing_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            peripheral_route_select_0_r <= pin_routing_pkg::ROUTE_SELECT_0_RESET;
            peripheral_route_select_1_r <= pin_routing_pkg::ROUTE_SELECT_1_RESET;
        end
        else if (write_go && w_strb_r[0])
        begin
            if (wr_sel == pin_routing_pkg::REG_SELECT_0)
            begin
                peripheral_route_select_0_r <= w_data_r[7:0];
            end
            if (wr_sel == pin_routing_pkg::REG_SELECT_1)
            begin
                peripheral_route_select_1_r <= w_data_r[7:0]
                    & pin_routing_pkg::ROUTE_SELECT_1_WRITE_MASK;
            end
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ----------------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------------
    assign s_axi_arready = !rvalid_r;
    assign read_go = s_axi_arvalid && !rvalid_r;
    assign rd_sel = decode_addr(s_axi_araddr);

    always_comb
    begin
        case (rd_sel)
            pin_routing_pkg::REG_SELECT_0: read_value = {24'h00_0000, peripheral_route_select_0_r};
            pin_routing_pkg::REG_SELECT_1: read_value = {24'h00_0000, peripheral_route_select_1_r};
            pin_routing_pkg::REG_STATUS:
                read_value = {{(31 - NUM_PINS){1'b0}}, overflow_r, pin_assigned_r};
            default: read_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rresp_r <= pin_routing_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end
        else if (read_go)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= read_value;
            rresp_r <= (rd_sel == pin_routing_pkg::REG_NONE)
                ? pin_routing_pkg::RESP_SLVERR : pin_routing_pkg::RESP_OKAY;
        end
        else if (s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ----------------------------------------------------------------------
    // Pin input synchroniser and filter
    // ----------------------------------------------------------------------
    // A pin level is accepted only once the second and third stages agree.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            pin_level_r <= '1;
        end
        else
        begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_level_r <= (sync2_r & ~(sync2_r ^ sync3_r)) | (pin_level_r & (sync2_r ^ sync3_r));
        end
    end

    // ----------------------------------------------------------------------
    // Route enables and slot assignment
    // ----------------------------------------------------------------------
    assign matrix_en = peripheral_route_select_1_r[pin_routing_pkg::ROUTE_MATRIX_ENABLE_BIT];

    always_comb
    begin
        sig_enable = '0;
        if (matrix_en) // RULE10
        begin
            sig_enable[pin_routing_pkg::SIG_SERIAL_TX] =
                peripheral_route_select_1_r[pin_routing_pkg::SECOND_SERIAL_ROUTE_BIT]; // RULE7
            sig_enable[pin_routing_pkg::SIG_SERIAL_RX] =
                peripheral_route_select_1_r[pin_routing_pkg::SECOND_SERIAL_ROUTE_BIT]; // RULE7
            sig_enable[pin_routing_pkg::SIG_COMPARATOR] =
                peripheral_route_select_0_r[pin_routing_pkg::COMPARATOR_ONE_ROUTE_BIT]; // RULE6
            sig_enable[pin_routing_pkg::SIG_TIMER_ZERO] =
                peripheral_route_select_0_r[pin_routing_pkg::TIMER_ZERO_INPUT_ROUTE_BIT]; // RULE5
            sig_enable[pin_routing_pkg::SIG_IRQ_ZERO] =
                peripheral_route_select_0_r[pin_routing_pkg::IRQ_ZERO_ROUTE_BIT]; // RULE4
            sig_enable[pin_routing_pkg::SIG_TIMER_ONE] =
                peripheral_route_select_0_r[pin_routing_pkg::TIMER_ONE_INPUT_ROUTE_BIT]; // RULE3
            sig_enable[pin_routing_pkg::SIG_IRQ_ONE] =
                peripheral_route_select_0_r[pin_routing_pkg::IRQ_ONE_ROUTE_BIT]; // RULE2
            sig_enable[pin_routing_pkg::SIG_TIMER_TWO] =
                peripheral_route_select_0_r[pin_routing_pkg::TIMER2_INPUT_ROUTE_BIT]; // RULE1
            sig_enable[pin_routing_pkg::SIG_TIMER_TWO_AUX] =
                peripheral_route_select_0_r[pin_routing_pkg::TIMER2_AUX_ROUTE_BIT];
            sig_enable[pin_routing_pkg::SIG_SYSCLK_OUT] =
                peripheral_route_select_0_r[pin_routing_pkg::SYSCLK_OUT_ROUTE_BIT];
        end
    end

    route_slot_assigner #(
        .NUM_PINS(NUM_PINS)
    ) u_assigner (
        .sig_enable(sig_enable),
        .pin_skip(pin_analog_mode), // RULE9
        .pin_valid(slot_valid),
        .pin_sig(slot_sig),
        .overflow(slot_overflow)
    );

    // ----------------------------------------------------------------------
    // Pin drive and peripheral input selection
    // ----------------------------------------------------------------------
    always_comb
    begin
        sig_drive = '0;
        sig_drive[pin_routing_pkg::SIG_SERIAL_TX] = second_serial_port_tx;
        sig_drive[pin_routing_pkg::SIG_COMPARATOR] = comparator_one_output;
        sig_drive[pin_routing_pkg::SIG_SYSCLK_OUT] = sysclk_level;
    end

    always_comb
    begin
        pin_out_nxt = '0;
        pin_oe_n_nxt = '1;
        sig_in_nxt = {pin_routing_pkg::SIG_COUNT{pin_routing_pkg::INPUT_IDLE_LEVEL}};
        for (int p = 0; p < NUM_PINS; p++)
        begin
            if (!matrix_en)
            begin
                pin_oe_n_nxt[p] = 1'b1; // RULE10
            end
            else if (slot_valid[p] && is_output_signal(slot_sig[p]))
            begin
                pin_out_nxt[p] = sig_drive[slot_sig[p]]; // RULE6
                pin_oe_n_nxt[p] = 1'b0;
            end
            else if (slot_valid[p])
            begin
                sig_in_nxt[slot_sig[p]] = pin_level_r[p]; // RULE8
            end
            else if (!pin_analog_mode[p])
            begin
                // With the matrix enabled, pins left free by the crossbar and not in analog input mode stay with the port latch
                pin_out_nxt[p] = gpio_out[p];
                pin_oe_n_nxt[p] = !gpio_drive[p];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out_r <= '0;
            pin_oe_n_r <= '1;
            sig_in_r <= {pin_routing_pkg::SIG_COUNT{pin_routing_pkg::INPUT_IDLE_LEVEL}};
            pin_assigned_r <= '0;
            overflow_r <= 1'b0;
        end
        else
        begin
            pin_out_r <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
            sig_in_r <= sig_in_nxt;
            pin_assigned_r <= slot_valid;
            overflow_r <= slot_overflow;
        end
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    assign pin_out = pin_out_r;
    assign pin_oe_n = pin_oe_n_r;
    assign pin_assigned = pin_assigned_r;
    assign second_serial_port_rx = sig_in_r[pin_routing_pkg::SIG_SERIAL_RX]; // RULE7
    assign timer_zero_count_input = sig_in_r[pin_routing_pkg::SIG_TIMER_ZERO]; // RULE5
    assign timer_one_count_input = sig_in_r[pin_routing_pkg::SIG_TIMER_ONE]; // RULE3
    assign timer_two_count_input = sig_in_r[pin_routing_pkg::SIG_TIMER_TWO]; // RULE1
    assign timer_two_aux_input = sig_in_r[pin_routing_pkg::SIG_TIMER_TWO_AUX];
    assign external_irq_zero_input_n = sig_in_r[pin_routing_pkg::SIG_IRQ_ZERO]; // RULE4
    assign external_irq_one_input_n = sig_in_r[pin_routing_pkg::SIG_IRQ_ONE]; // RULE2
    // Pull-ups are on while the disable bit is clear
    assign weak_pullup_enable = !peripheral_route_select_1_r[pin_routing_pkg::WEAK_PULLUP_DISABLE_BIT];
    assign route_matrix_enable = matrix_en;

endmodule : peripheral_pin_routing

// >>> verification/pin_routing_checker.sv
// Checker: bus handshakes and crossbar outputs of the pin routing block.
// Sees only the top module's ports; attached by the bind at the foot.
module pin_routing_checker #(
    parameter int NUM_PINS = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [NUM_PINS-1:0] pin_oe_n,
    input wire logic [NUM_PINS-1:0] pin_assigned,
    input wire logic [NUM_PINS-1:0] pin_analog_mode,
    input wire logic route_matrix_enable,
    input wire logic timer_zero_count_input,
    input wire logic external_irq_zero_input_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_b_due; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid; endproperty
    a_b_due: assert property (p_b_due) else $error("write response late");
    property p_r_due; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_due: assert property (p_r_due) else $error("read response late");
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write accepted while busy");
    // Two cycles low so the one-cycle lag of the pin registers has passed
    property p_off; !route_matrix_enable && !$past(route_matrix_enable)
        |-> &pin_oe_n && pin_assigned == '0; endproperty
    a_off: assert property (p_off) else $error("pin driven while matrix off");
    property p_analog; (pin_assigned & $past(pin_analog_mode)) == '0; endproperty
    a_analog: assert property (p_analog) else $error("analog pin assigned");
    property p_prio; pin_assigned[1] |-> pin_assigned[0] || $past(pin_analog_mode[0]);
    endproperty
    a_prio: assert property (p_prio) else $error("pin skipped out of order");
    property p_idle; !route_matrix_enable && !$past(route_matrix_enable)
        |-> timer_zero_count_input && external_irq_zero_input_n; endproperty
    a_idle: assert property (p_idle) else $error("unrouted input not idle");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (pin_assigned != '0);
endmodule : pin_routing_checker

bind peripheral_pin_routing pin_routing_checker #(.NUM_PINS(NUM_PINS)) chk (.*);

// >>> verification/peripheral_pin_routing_tb.sv
// Testbench: drives the register bus and pins, checks the routed levels.
// Assumes the design defaults NUM_PINS 8 and ADDR_W 8.
module peripheral_pin_routing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pin_in = 8'hFF;
    logic [7:0] pin_analog_mode = 8'h00, gpio_out = 8'h00, gpio_drive = 8'h00;
    logic [7:0] pin_out, pin_oe_n, pin_assigned;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic second_serial_port_tx = 1'b1, comparator_one_output = 1'b0, sysclk_level = 1'b0;
    logic second_serial_port_rx, timer_zero_count_input, timer_one_count_input;
    logic timer_two_count_input, timer_two_aux_input, weak_pullup_enable;
    logic route_matrix_enable, external_irq_zero_input_n, external_irq_one_input_n;
    int fail_count = 0;
    int checked = 0;
    wire [5:0] ins = {timer_two_aux_input, timer_two_count_input, external_irq_one_input_n,
        timer_one_count_input, external_irq_zero_input_n, timer_zero_count_input};

    peripheral_pin_routing uut (.*);

    task automatic results;
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic tmo(input int n);
        if (n >= 40)
        begin
            fail_count++;
            results();
        end
    endtask : tmo

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        tmo(n);
        cmp(s_axi_bresp, er);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            s_axi_rready <= s_axi_rvalid;
        end
        s_axi_rready <= 1'b0;
        tmo(n);
        cmp(s_axi_rdata, ed);
        cmp(s_axi_rresp, er);
    endtask : rd

    task automatic t_off;
        rd(8'h00, 32'h00, 2'h0);
        rd(8'h04, 32'h00, 2'h0);
        cmp({weak_pullup_enable, route_matrix_enable, pin_oe_n, pin_assigned}, 32'h2FF00);
        // Route bits and port drive set while the matrix stays off
        gpio_drive <= 8'hFF;
        pin_in <= 8'h00;
        wr(8'h00, 32'hFF, 2'h0);
        wr(8'h04, 32'h84, 2'h0);
        repeat (6) @(posedge aclk);
        cmp({weak_pullup_enable, pin_oe_n, pin_assigned}, 32'h0FF00);
        cmp(ins, 32'h3F);
        gpio_drive <= 8'h00;
    endtask : t_off

    task automatic t_pins;
        pin_analog_mode <= 8'h02;
        pin_in <= 8'hFB;
        comparator_one_output <= 1'b1;
        second_serial_port_tx <= 1'b0;
        wr(8'h00, 32'h01, 2'h0);
        wr(8'h04, 32'h44, 2'h0);
        repeat (6) @(posedge aclk);
        cmp(pin_assigned, 32'h0D);
        cmp(pin_oe_n, 32'hF6);
        cmp(pin_out & 8'h09, 32'h08);
        cmp(second_serial_port_rx, 32'h0);
        rd(8'h08, 32'h0D, 2'h0);
    endtask : t_pins

    task automatic t_inputs;
        int b;
        pin_analog_mode <= 8'h00;
        pin_in <= 8'hFE;
        wr(8'h04, 32'h40, 2'h0);
        for (b = 1; b < 7; b++)
        begin
            wr(8'h00, 32'h1 << b, 2'h0);
            repeat (6) @(posedge aclk);
            cmp(ins, ~(32'h1 << (b - 1)) & 32'h3F);
        end
        wr(8'h00, 32'h00, 2'h0);
        repeat (3) @(posedge aclk);
        cmp(ins, 32'h3F);
    endtask : t_inputs

    task automatic t_err;
        rd(8'h0C, 32'h00, 2'h2);
        wr(8'h08, 32'hFF, 2'h2);
        wr(8'h04, 32'hFF, 2'h0);
        rd(8'h04, 32'hDC, 2'h0);
    endtask : t_err

    initial
    begin
        forever #25 aclk = ~aclk;
    end

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_off();
        t_pins();
        t_inputs();
        t_err();
        results();
    end
endmodule : peripheral_pin_routing_tb
